/* shared/arc_timer_params.svh */
// constants for the reload/capture timer: offsets, fields, resets, timing
`ifndef ARC_TIMER_PARAMS_SVH
`define ARC_TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL0 8'h00
`define OFS_COUNT0 8'h04
`define OFS_RC0 8'h08
`define OFS_CTRL1 8'h10
`define OFS_COUNT1 8'h14
`define OFS_RC1 8'h18
`define OFS_STATUS 8'h20
`define OFS_MASK 8'h24
`define CH_STRIDE 8'h10

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_CAPTURE 1
`define CTRL_DIR 2
`define CTRL_TRIG_EN 3
`define CTRL_RISING 4
`define CTRL_EXT_COUNT 5
`define CTRL_W 6

// ----------------------------------------------------------------
// status and reset values
// ----------------------------------------------------------------
`define ST_W 4
`define CTRL_RESET 6'h00
`define MASK_RESET 4'h0
`define COUNT_RESET 16'h0000
`define RC_RESET 16'h0000
`define COUNT_TOP 16'hffff
`define CAPTURE_RELOAD 16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REF_CLK_PERIOD_NS 40
`define TICK_DIV 12
`define TICK_LAST (4'(`TICK_DIV - 1))

`endif

/* shared/arc_timer_pkg.sv */
// types of the reload/capture timer
`default_nettype none
package arc_timer_pkg;

    // state of one timer channel
    typedef struct packed {
        logic [1:0] cnt_sync;
        logic cnt_prev;
        logic [1:0] trg_sync;
        logic trg_prev;
        logic [3:0] prescale;
        logic [15:0] count;
        logic [15:0] rc;
        logic reload_ev;
        logic capture_ev;
    } chan_state_t;

    // state of the register block
    typedef struct packed {
        logic [1:0][5:0] ctrl;
        logic [3:0] status;
        logic [3:0] mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regs_state_t;

endpackage
`default_nettype wire

/* src/arc_timer_chan.sv */
// one 16-bit auto-reload / capture timer channel
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arc_timer_params.svh"

module arc_timer_chan (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic i_capture_mode,
    input wire logic i_dir_ctrl,
    input wire logic i_trig_en,
    input wire logic i_trig_rising,
    input wire logic i_ext_count,
    input wire logic i_count_pin,
    input wire logic i_trigger_pin,
    input wire logic i_wr_count,
    input wire logic i_wr_rc,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_count,
    output logic [15:0] o_rc,
    output logic o_reload_ev,
    output logic o_capture_ev
);

    arc_timer_pkg::chan_state_t r;
    arc_timer_pkg::chan_state_t s;
    logic tick;
    logic trg_edge;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s = r;
        s.reload_ev = 1'b0;
        s.capture_ev = 1'b0;
        // two-stage sync, edge from stages two and three
        s.cnt_sync = {r.cnt_sync[0], i_count_pin};
        s.cnt_prev = r.cnt_sync[1];
        s.trg_sync = {r.trg_sync[0], i_trigger_pin};
        s.trg_prev = r.trg_sync[1];
        trg_edge = i_trig_rising ? (~r.trg_prev & r.trg_sync[1])
                                 : (r.trg_prev & ~r.trg_sync[1]);
        // falling edge of count pin in counter operation
        // divide by twelve in timer operation
        if (i_ext_count) begin
            tick = r.cnt_prev & ~r.cnt_sync[1];
        end else begin
            tick = (r.prescale == `TICK_LAST);
        end
        if (i_run && !i_ext_count) begin
            s.prescale = tick ? 4'h0 : r.prescale + 4'h1;
        end
        // counting only while run is set
        if (i_run) begin
            if (i_capture_mode) begin
                // count up from zero, wrap reloads zero
                if (tick) begin
                    if (r.count == `COUNT_TOP) begin
                        s.count = `CAPTURE_RELOAD;
                        s.reload_ev = 1'b1;
                    end else begin
                        s.count = r.count + 16'h1;
                    end
                end
                if (i_trig_en && trg_edge) begin
                    s.rc = r.count;
                    s.capture_ev = 1'b1;
                end
            end else if (i_dir_ctrl) begin
                // trigger level sets direction, no event
                if (tick && r.trg_sync[1]) begin
                    // upward reloads from rc after top
                    s.count = (r.count == `COUNT_TOP) ? r.rc
                                                      : r.count + 16'h1;
                end else if (tick) begin
                    // downward underflows at rc to top
                    s.count = (r.count == r.rc) ? `COUNT_TOP
                                                : r.count - 16'h1;
                end
            end else begin
                if ((tick && r.count == `COUNT_TOP)
                        || (i_trig_en && trg_edge)) begin
                    s.count = r.rc;
                    s.reload_ev = 1'b1;
                end else if (tick) begin
                    s.count = r.count + 16'h1;
                end
            end
        end
        // software writes take precedence
        if (i_wr_count) begin
            s.count = i_wdata;
        end
        if (i_wr_rc) begin
            s.rc = i_wdata;
        end
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    // outputs
    assign o_count = r.count;
    assign o_rc = r.rc;
    assign o_reload_ev = r.reload_ev;
    assign o_capture_ev = r.capture_ev;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    prescale_wrap_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_run && !i_ext_count)
        |=> r.prescale == (($past(r.prescale) == `TICK_LAST) ? 4'h0
                           : $past(r.prescale) + 4'h1)
        ) else $error("prescaler did not step modulo twelve");

    prescale_range_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        r.prescale <= `TICK_LAST
        ) else $error("prescaler left its twelve state range");

    pin_edge_count_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_run && i_ext_count && !i_wr_count && r.cnt_prev
            && !r.cnt_sync[1] && r.count != `COUNT_TOP
            && (i_capture_mode
                || (!i_dir_ctrl && !(i_trig_en && trg_edge))))
        |=> r.count == $past(r.count) + 16'h1
        ) else $error("falling count edge not counted");

    overflow_reload_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_run && !i_capture_mode && !i_dir_ctrl && tick
            && r.count == `COUNT_TOP && !i_wr_count && !i_wr_rc)
        |=> (r.count == $past(r.rc)) && o_reload_ev
        ) else $error("overflow did not reload with event");

    down_underflow_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_run && !i_capture_mode && i_dir_ctrl && tick
            && !r.trg_sync[1] && r.count == r.rc && !i_wr_count)
        |=> (r.count == `COUNT_TOP) && !o_reload_ev
        ) else $error("down count did not underflow to top");

    capture_copy_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_run && i_capture_mode && i_trig_en && trg_edge && !i_wr_rc)
        |=> (r.rc == $past(r.count)) && o_capture_ev
        ) else $error("capture edge did not store count");

    capture_wrap_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_run && i_capture_mode && tick && r.count == `COUNT_TOP
            && !i_wr_count)
        |=> (r.count == `CAPTURE_RELOAD) && o_reload_ev
        ) else $error("capture mode wrap did not reload zero");

    idle_hold_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (!i_run && !i_wr_count) |=> $stable(r.count)
        ) else $error("count moved while stopped");

endmodule
`default_nettype wire

/* src/auto_reload_capture_timer16.sv */
// two-channel 16-bit reload/capture timer behind an APB slave
// Notes on behaviour
// - counter runs in auto-reload mode or single-channel capture mode
// - timer operation advances once every twelve clocks
// - counter operation advances on each falling edge of count pin
// - count pin edges no faster than one per 24 clocks
// - auto-reload without direction counts up, top overflow reloads rc
// - reload by overflow only or also by chosen trigger edge
// - each auto-reload event without direction control raises interrupt
// - direction control: trigger level sets direction, no interrupt
// - counting up from reload value, top overflow reloads rc
// - counting down from top, reaching rc reloads top
// - capture mode counts up from zero, overflow reloads zero
// - capture mode: chosen trigger edge copies count into rc
// - capture mode interrupts on every reload and capture
`timescale 1ns/1ps
`default_nettype none
`include "arc_timer_params.svh"

module auto_reload_capture_timer16 (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [1:0] i_count_pin,
    input wire logic [1:0] i_trigger_pin,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq
);

    arc_timer_pkg::regs_state_t r;
    arc_timer_pkg::regs_state_t s;
    logic [1:0][15:0] count;
    logic [1:0][15:0] rc;
    logic [1:0] reload_ev;
    logic [1:0] capture_ev;
    logic [1:0] wr_count;
    logic [1:0] wr_rc;
    logic [3:0] status_set;
    logic access;
    logic wr_go;
    logic mapped;
    logic [31:0] rdata;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    // two identical, separately controlled channels
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            assign wr_count[ch] = wr_go
                && i_paddr == `OFS_COUNT0 + 8'(ch) * `CH_STRIDE;
            assign wr_rc[ch] = wr_go
                && i_paddr == `OFS_RC0 + 8'(ch) * `CH_STRIDE;
            // reload and capture events feed status bits
            assign status_set[2*ch] = reload_ev[ch];
            assign status_set[2*ch+1] = capture_ev[ch];
            // mode and source from the control word
            arc_timer_chan u_chan (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_run(r.ctrl[ch][`CTRL_RUN]),
                .i_capture_mode(r.ctrl[ch][`CTRL_CAPTURE]),
                .i_dir_ctrl(r.ctrl[ch][`CTRL_DIR]),
                .i_trig_en(r.ctrl[ch][`CTRL_TRIG_EN]),
                .i_trig_rising(r.ctrl[ch][`CTRL_RISING]),
                .i_ext_count(r.ctrl[ch][`CTRL_EXT_COUNT]),
                .i_count_pin(i_count_pin[ch]),
                .i_trigger_pin(i_trigger_pin[ch]),
                .i_wr_count(wr_count[ch]),
                .i_wr_rc(wr_rc[ch]),
                .i_wdata(i_pwdata[15:0]),
                .o_count(count[ch]),
                .o_rc(rc[ch]),
                .o_reload_ev(reload_ev[ch]),
                .o_capture_ev(capture_ev[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------
    always_comb begin
        rdata = 32'h0;
        mapped = 1'b1;
        case (i_paddr)
            `OFS_CTRL0: rdata = {26'h0, r.ctrl[0]};
            `OFS_COUNT0: rdata = {16'h0, count[0]};
            `OFS_RC0: rdata = {16'h0, rc[0]};
            `OFS_CTRL1: rdata = {26'h0, r.ctrl[1]};
            `OFS_COUNT1: rdata = {16'h0, count[1]};
            `OFS_RC1: rdata = {16'h0, rc[1]};
            `OFS_STATUS: rdata = {28'h0, r.status};
            `OFS_MASK: rdata = {28'h0, r.mask};
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state: bus, control, status, interrupt
    // ------------------------------------------------------------
    always_comb begin
        s = r;
        // one wait state: ready rises in the second access cycle
        access = i_psel & i_penable & ~r.pready;
        wr_go = i_psel & i_penable & r.pready & i_pwrite & ~r.pslverr;
        s.pready = access;
        s.pslverr = access & ~mapped;
        s.prdata = (access && !i_pwrite && mapped) ? rdata : 32'h0;
        if (wr_go && i_paddr == `OFS_CTRL0) begin
            s.ctrl[0] = i_pwdata[`CTRL_W-1:0];
        end
        if (wr_go && i_paddr == `OFS_CTRL1) begin
            s.ctrl[1] = i_pwdata[`CTRL_W-1:0];
        end
        if (wr_go && i_paddr == `OFS_MASK) begin
            s.mask = i_pwdata[`ST_W-1:0];
        end
        // sticky flags, a new event beats the clear
        s.status = r.status;
        if (wr_go && i_paddr == `OFS_STATUS) begin
            s.status = r.status & ~i_pwdata[`ST_W-1:0];
        end
        s.status = s.status | status_set;
        s.irq = |(s.status & s.mask);
    end

    // state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            r <= '0;
        end else begin
            r <= s;
        end
    end

    // outputs, all from flip-flops
    assign o_prdata = r.prdata;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_irq = r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    apb_wait_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_psel && i_penable && !o_pready) |=> o_pready
        ) else $error("apb access not answered after one wait");

    reload_flag_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        reload_ev[0] |-> ##1 r.status[0]
        ) else $error("reload event did not set its flag");

    capture_irq_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (capture_ev[1] && r.mask[3] && !(wr_go && i_paddr == `OFS_MASK))
        |=> o_irq && r.status[3]
        ) else $error("capture event did not raise interrupt");

    dir_no_event_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (r.ctrl[0][`CTRL_DIR] && !r.ctrl[0][`CTRL_CAPTURE])
        ##1 (r.ctrl[0][`CTRL_DIR] && !r.ctrl[0][`CTRL_CAPTURE])
        |-> !reload_ev[0] && !capture_ev[0]
        ) else $error("event raised under direction control");

endmodule
`default_nettype wire

/* verif/pin_source.sv */
// model of the external count and trigger sources of both channels
`timescale 1ns/1ps
`default_nettype none

module pin_source (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [1:0] i_pulse_en,
    input wire logic [1:0] i_trig_level,
    output logic [1:0] o_count_pin,
    output logic [1:0] o_trigger_pin
);
    logic [3:0] half_r;

    // edge rate limit
    // count pins toggle every 12 clocks, one falling edge per 24 clocks
    always_ff @(posedge i_ref_clk) begin
        o_trigger_pin <= i_trig_level;
        if (!i_rst_b || i_pulse_en == 2'b00) begin
            half_r <= 4'h0;
            if (!i_rst_b) begin
                o_count_pin <= 2'b11; // high after reset; between bursts the pin holds its last level
            end
        end else if (half_r == 4'hb) begin
            half_r <= 4'h0;
            o_count_pin <= o_count_pin ^ i_pulse_en;
        end else begin
            half_r <= half_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* verif/auto_reload_capture_timer16_bench.sv */
// self-checking bench of the two-channel reload/capture timer
`timescale 1ns/1ps
`default_nettype none
`include "arc_timer_params.svh"

module auto_reload_capture_timer16_bench;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] count_pin, trigger_pin, pulse_en, trig_level;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    auto_reload_capture_timer16 dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_count_pin(count_pin),
        .i_trigger_pin(trigger_pin), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_irq(irq));

    pin_source pins (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
        .i_pulse_en(pulse_en), .i_trig_level(trig_level),
        .o_count_pin(count_pin), .o_trigger_pin(trigger_pin));

    // ------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // cut a hang short after far more cycles than the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            final_report();
        end
    end

    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // one apb transfer; read data and error are taken at the ready edge
    // a slave that never answers is cut short by the hang guard
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(e, rd);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        logic [7:0] ofs [8] = '{`OFS_CTRL0, `OFS_COUNT0, `OFS_RC0,
            `OFS_CTRL1, `OFS_COUNT1, `OFS_RC1, `OFS_STATUS, `OFS_MASK};
        foreach (ofs[i]) begin
            rchk(ofs[i], 32'h0000_0000);
        end
        check(32'h0, irq);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        check(32'h1, er);
        check(32'h0, rd);
        apb(1'b1, `OFS_CTRL0, 32'hffff_fffe);
        rchk(`OFS_CTRL0, 32'h0000_003e);
        apb(1'b1, `OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, `OFS_STATUS, 32'h0000_000f);
        rchk(`OFS_STATUS, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic test_timer();
        apb(1'b1, `OFS_RC0, 32'h0000_1234);
        apb(1'b1, `OFS_COUNT0, 32'h0000_fffe);
        apb(1'b1, `OFS_MASK, 32'h0000_0001);
        apb(1'b1, `OFS_CTRL0, 32'h0000_0001);
        idle(5);
        rchk(`OFS_COUNT0, 32'h0000_fffe);
        idle(16);
        rchk(`OFS_COUNT0, 32'h0000_1234);
        rchk(`OFS_STATUS, 32'h0000_0001);
        check(32'h1, irq);
        apb(1'b1, `OFS_STATUS, 32'h0000_0001);
        idle(2);
        check(32'h0, irq);
        apb(1'b1, `OFS_CTRL0, 32'h0000_0000);
        $display("test timer done");
    endtask

    task automatic test_direction();
        trig_level[0] <= 1'b0;
        apb(1'b1, `OFS_RC0, 32'h0000_0100);
        apb(1'b1, `OFS_COUNT0, 32'h0000_0101);
        apb(1'b1, `OFS_CTRL0, 32'h0000_0005);
        idle(24);
        rchk(`OFS_COUNT0, 32'h0000_ffff);
        // trigger high turns the count upward; top then reloads rc
        trig_level[0] <= 1'b1;
        idle(26);
        rchk(`OFS_COUNT0, 32'h0000_0100);
        rchk(`OFS_STATUS, 32'h0000_0000);
        check(32'h0, irq);
        apb(1'b1, `OFS_CTRL0, 32'h0000_0000);
        trig_level[0] <= 1'b0;
        $display("test direction done");
    endtask

    task automatic test_trigger_reload();
        apb(1'b1, `OFS_RC0, 32'h0000_4321);
        apb(1'b1, `OFS_COUNT0, 32'h0000_0010);
        // counter operation with an idle pin: only the trigger edge acts
        apb(1'b1, `OFS_CTRL0, 32'h0000_0039);
        trig_level[0] <= 1'b1;
        idle(6);
        rchk(`OFS_COUNT0, 32'h0000_4321);
        rchk(`OFS_STATUS, 32'h0000_0001);
        apb(1'b1, `OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, `OFS_STATUS, 32'h0000_0001);
        $display("test trigger reload done");
    endtask

    task automatic test_capture();
        apb(1'b1, `OFS_COUNT1, 32'h0000_fffe);
        apb(1'b1, `OFS_MASK, 32'h0000_000c);
        apb(1'b1, `OFS_CTRL1, 32'h0000_002b);
        pulse_en <= 2'b10;
        idle(120);
        pulse_en <= 2'b00;
        idle(8);
        rchk(`OFS_COUNT1, 32'h0000_0003);
        rchk(`OFS_COUNT0, 32'h0000_4321);
        trig_level[1] <= 1'b0;
        idle(8);
        rchk(`OFS_RC1, 32'h0000_0003);
        rchk(`OFS_STATUS, 32'h0000_000c);
        check(32'h1, irq);
        $display("test capture done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pulse_en = 2'b00;
        trig_level = 2'b11;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        test_reset();
        test_timer();
        test_direction();
        test_trigger_reload();
        test_capture();
        final_report();
    end
endmodule
`default_nettype wire
